// ===== verilog/fsbl_consts.vh
// Purpose: shared constants of the flash security and block lock logic
// Assumes: 8-bit opcodes, 24-bit byte addresses, 64 KB blocks, 4 KB sectors
// Notes: definitions only
`ifndef FSBL_CONSTS_VH
`define FSBL_CONSTS_VH

// ----------------------------------------------------------------
// command opcodes
// ----------------------------------------------------------------
`define FSBL_OP_RD_SEC 8'h4b
`define FSBL_OP_WR_SEC 8'h4f
`define FSBL_OP_PROT_SEL 8'h6a
`define FSBL_OP_FAIL_CLR 8'h30
`define FSBL_OP_SGL_LOCK 8'h36
`define FSBL_OP_SGL_UNLOCK 8'h39
`define FSBL_OP_GANG_LOCK 8'h7e
`define FSBL_OP_GANG_UNLOCK 8'h98
`define FSBL_OP_LOCK_RD 8'h3c

// ----------------------------------------------------------------
// security status register field positions
// ----------------------------------------------------------------
`define FSBL_SEC_FACTORY 0
`define FSBL_SEC_CUST_LOCK 1
`define FSBL_SEC_CONT_PROG 4
`define FSBL_SEC_PROG_FAIL 5
`define FSBL_SEC_ERASE_FAIL 6
`define FSBL_SEC_PROT_SEL 7

// ----------------------------------------------------------------
// volatile reset values
// ----------------------------------------------------------------
`define FSBL_RST_FAIL 1'b0
`define FSBL_RST_PROT_SEL 1'b0

// ----------------------------------------------------------------
// lock bit map: 128 blocks, then 16 bottom and 16 top sectors
// ----------------------------------------------------------------
`define FSBL_NUM_LOCKS 160
`define FSBL_IDX_W 8
`define FSBL_BOT_BASE 4'h8
`define FSBL_TOP_BASE 4'h9
`define FSBL_BLK_FIRST 7'h00
`define FSBL_BLK_LAST 7'h7f
`define FSBL_ADDR_BYTES 3'd4
`define FSBL_CMD_BYTES 3'd1

`endif

// ===== verilog/fsbl_lock_mem.v
// Purpose: volatile per-block / per-sector lock bits with gang access
// Assumes: one write or one gang operation per cycle
// Notes: both read ports come out of registers
`timescale 1ns/1ps
module fsbl_lock_mem #(
  parameter N = 160,
  parameter IW = 8
) (
  input wire clk_sys,
  input wire srst,
  input wire initAll,
  input wire write_enable_cmd,
  input wire [IW-1:0] wrIdx,
  input wire wrVal,
  input wire gangEn,
  input wire gangVal,
  input wire [IW-1:0] rdIdxA,
  output reg rdBitA,
  input wire [IW-1:0] rdIdxB,
  output reg rdBitB
);
  reg [N-1:0] bits_q;

  // power-on fill follows the scheme bit; gang wins over a single write
  always @(posedge clk_sys) begin
    if (srst) begin
      bits_q <= {N{initAll}};
    end else if (gangEn) begin
      bits_q <= {N{gangVal}};
    end else if (write_enable_cmd) begin
      bits_q[wrIdx] <= wrVal;
    end
  end

  // registered reads; out-of-range index reads as locked to fail safe
  always @(posedge clk_sys) begin
    if (srst) begin
      rdBitA <= 1'b1;
      rdBitB <= 1'b1;
    end else begin
      rdBitA <= (rdIdxA < N) ? bits_q[rdIdxA] : 1'b1;
      rdBitB <= (rdIdxB < N) ? bits_q[rdIdxB] : 1'b1;
    end
  end
endmodule // fsbl_lock_mem

// ===== verilog/fsbl_security_lock.v
// Purpose: security status register and block lock command logic of a serial flash
// Assumes: spi mode 0/3, sclk at most clk_sys/8, pins asynchronous to clk_sys
// Notes: array engines and status register live outside; they supply events and enables
`timescale 1ns/1ps
`include "fsbl_consts.vh"

// Operation
// - security register readable at any time
// - security byte repeats until chip select rises
// - bit 0 shows factory otp lock
// - bit 1 settable once, then frozen
// - bit 4 mirrors continuous program mode
// - bit 5 sticky program fail, clear 30h
// - bit 6 sticky erase fail, clear 30h
// - volatile bits reset zero, bits 3:2 reserved
// - security write needs no write enable
// - security write rejected off byte boundary
// - scheme bit starts 0, set once only
// - range and block schemes mutually exclusive
// - power-on locks all when scheme bit set
// - block mode needs unlock before program/erase
// - range bits frozen when disable and pin low
// - block mode pin low protects everything
// - select command sets bit 7, enables locks
// - 36h locks one unit, 39h unlocks
// - lock bit per sector edge and block
// - 7Eh locks all, 98h unlocks all
// - 3Ch reads addressed lock bit
// - lock read first byte shows protection
module fsbl_security_lock (
  input wire clk_sys,
  input wire srst,
  input wire csN,
  input wire sclk,
  input wire si,
  input wire wpN,
  output reg soOut,
  output reg soEnN,
  input wire opBusy,
  input wire contProgActive,
  input wire progFailEvt,
  input wire eraseFailEvt,
  input wire otpModeActive,
  input wire writeEnableLatch,
  input wire statusWriteDisable,
  input wire rangeProtHit,
  input wire factoryOtpLock,
  input wire nvCustLock,
  input wire nvProtSel,
  input wire [23:0] qryAddr,
  output reg qryProtected,
  output reg rangeBitsLocked,
  output reg custLockProgram,
  output reg protSelProgram,
  output reg welClear,
  output reg blockSchemeActive
);

  // ----------------------------------------------------------------
  // frame states
  // ----------------------------------------------------------------
  localparam [2:0] ST_CMD = 3'd0;
  localparam [2:0] ST_ADDR = 3'd1;
  localparam [2:0] ST_SEC = 3'd2;
  localparam [2:0] ST_LOCK = 3'd3;
  localparam [2:0] ST_IGN = 3'd4;

  // address to lock index: edge blocks split into 4 KB sectors
  function [`FSBL_IDX_W-1:0] lockIdx;
    input [23:0] a;
    begin
      if (a[22:16] == `FSBL_BLK_FIRST)
        lockIdx = {`FSBL_BOT_BASE, a[15:12]};
      else if (a[22:16] == `FSBL_BLK_LAST)
        lockIdx = {`FSBL_TOP_BASE, a[15:12]};
      else
        lockIdx = {1'b0, a[22:16]};
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // bit order: 0 csN, 1 sclk, 2 si, 3 wpN
  reg [3:0] pinS1_q;
  reg [3:0] pinS2_q;
  reg [3:0] pinS3_q;
  reg [3:0] pinF_q;
  reg sclkPrev_q;
  reg csPrev_q;
  wire [3:0] pinDiff;
  wire csLow;
  wire sclkRise;
  wire sclkFall;
  wire csRise;
  wire wpLow;

  // three stages; a level is accepted only once stages two and three agree
  always @(posedge clk_sys) begin
    if (srst) begin
      pinS1_q <= 4'hf;
      pinS2_q <= 4'hf;
      pinS3_q <= 4'hf;
      pinF_q <= 4'hf;
      sclkPrev_q <= 1'b1;
      csPrev_q <= 1'b1;
    end else begin
      pinS1_q <= {wpN, si, sclk, csN};
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
      pinF_q <= (~pinDiff & pinS2_q) | (pinDiff & pinF_q);
      sclkPrev_q <= pinF_q[1];
      csPrev_q <= pinF_q[0];
    end
  end

  assign pinDiff = pinS2_q ^ pinS3_q;
  assign csLow = ~pinF_q[0];
  assign sclkRise = csLow & pinF_q[1] & ~sclkPrev_q;
  assign sclkFall = csLow & ~pinF_q[1] & sclkPrev_q;
  assign csRise = pinF_q[0] & ~csPrev_q;
  assign wpLow = ~pinF_q[3];

  // ----------------------------------------------------------------
  // security status register bits
  // ----------------------------------------------------------------
  reg custLock_q;
  reg protSel_q;
  reg progFail_q;
  reg eraseFail_q;
  reg contProg_q;
  wire [7:0] secReg;
  reg failClr;
  reg custLockSet;
  reg protSelSet;

  // non-volatile copies are caught at reset; reserved bits read zero
  assign secReg = {protSel_q, eraseFail_q, progFail_q, contProg_q, 2'b00,
                   custLock_q, factoryOtpLock};

  // hardware set wins over a clear in the same cycle
  always @(posedge clk_sys) begin
    if (srst) begin
      custLock_q <= nvCustLock;
      protSel_q <= nvProtSel;
      progFail_q <= `FSBL_RST_FAIL;
      eraseFail_q <= `FSBL_RST_FAIL;
      contProg_q <= 1'b0;
    end else begin
      contProg_q <= contProgActive;
      progFail_q <= progFailEvt | (progFail_q & ~failClr);
      eraseFail_q <= eraseFailEvt | (eraseFail_q & ~failClr);
      if (custLockSet)
        custLock_q <= 1'b1;
      if (protSelSet)
        protSel_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // serial frame decoder
  // ----------------------------------------------------------------
  reg [2:0] state_q;
  reg [2:0] bitCnt_q;
  reg [2:0] byteCnt_q;
  reg [7:0] shIn_q;
  reg [7:0] cmd_q;
  reg [23:0] addr_q;
  reg [7:0] shOut_q;
  reg [2:0] outCnt_q;
  wire [7:0] inByte;
  wire lockRdBit;
  wire [7:0] outSrc;
  assign inByte = {shIn_q[6:0], pinF_q[2]};
  // lock read: status in bit 0, remaining bits zero
  assign outSrc = (state_q == ST_LOCK) ? {7'h00, lockRdBit} : secReg;
  // input side samples on rising sclk; chip select high restarts the frame
  always @(posedge clk_sys) begin
    if (srst || !csLow) begin
      state_q <= ST_CMD;
      bitCnt_q <= 3'd0;
      byteCnt_q <= 3'd0;
      shIn_q <= 8'h00;
      if (srst) begin
        cmd_q <= 8'h00;
        addr_q <= 24'h000000;
      end
    end else if (sclkRise) begin
      shIn_q <= inByte;
      bitCnt_q <= bitCnt_q + 3'd1;
      if (bitCnt_q == 3'd7) begin
        if (byteCnt_q != 3'd7)
          byteCnt_q <= byteCnt_q + 3'd1;  // saturates so long frames never alias
        case (state_q)
          ST_CMD: begin
            cmd_q <= inByte;
            if (inByte == `FSBL_OP_RD_SEC)
              state_q <= ST_SEC;
            else if (inByte == `FSBL_OP_SGL_LOCK || inByte == `FSBL_OP_SGL_UNLOCK ||
                     inByte == `FSBL_OP_LOCK_RD)
              state_q <= ST_ADDR;
            else
              state_q <= ST_IGN;
          end
          ST_ADDR: begin
            addr_q <= {addr_q[15:0], inByte};
            if (byteCnt_q == 3'd3) begin
              // lock read only exists once block mode is selected
              if (cmd_q == `FSBL_OP_LOCK_RD && protSel_q)
                state_q <= ST_LOCK;
              else
                state_q <= ST_IGN;
            end
          end
          ST_SEC, ST_LOCK: state_q <= state_q;
          default: state_q <= ST_IGN;
        endcase
      end
    end
  end

  // output side shifts msb first on falling sclk, reloading a fresh byte every eighth fall
  always @(posedge clk_sys) begin
    if (srst || !csLow) begin
      soOut <= 1'b0;
      soEnN <= 1'b1;
      shOut_q <= 8'h00;
      outCnt_q <= 3'd0;
    end else if (state_q == ST_SEC || state_q == ST_LOCK) begin
      soEnN <= 1'b0;
      if (sclkFall) begin
        outCnt_q <= outCnt_q + 3'd1;
        soOut <= (outCnt_q == 3'd0) ? outSrc[7] : shOut_q[7];
        shOut_q <= (outCnt_q == 3'd0) ? {outSrc[6:0], 1'b0} : {shOut_q[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // command execution at chip select rise
  // ----------------------------------------------------------------
  reg gangEn;
  reg gangVal;
  reg sglEn;
  reg sglVal;
  wire exact1;
  wire exact4;
  wire wrOk;
  wire lockOk;

  // a command acts only if the frame ended exactly after its last byte
  assign exact1 = csRise && bitCnt_q == 3'd0 && byteCnt_q == `FSBL_CMD_BYTES;
  assign exact4 = csRise && bitCnt_q == 3'd0 && byteCnt_q == `FSBL_ADDR_BYTES;
  // writes need idle engines and stay off while the otp area is mapped
  assign wrOk = !opBusy && !otpModeActive;
  // lock commands need block mode and a latched write enable
  assign lockOk = wrOk && protSel_q && writeEnableLatch;
  always @* begin
    failClr = 1'b0;
    custLockSet = 1'b0;
    protSelSet = 1'b0;
    gangEn = 1'b0;
    gangVal = (cmd_q == `FSBL_OP_GANG_LOCK);  // value only; the enable decides
    sglEn = 1'b0;
    sglVal = (cmd_q == `FSBL_OP_SGL_LOCK);  // value only; the enable decides
    if (exact1) begin
      case (cmd_q)
        `FSBL_OP_FAIL_CLR: failClr = 1'b1;
        // no write enable needed; once set the bit is never rewritten
        `FSBL_OP_WR_SEC: custLockSet = wrOk && !custLock_q;
        `FSBL_OP_PROT_SEL: protSelSet = wrOk && !protSel_q;
        `FSBL_OP_GANG_LOCK, `FSBL_OP_GANG_UNLOCK: gangEn = lockOk;
        default: gangEn = 1'b0;
      endcase
    end else if (exact4) begin
      case (cmd_q)
        `FSBL_OP_SGL_LOCK, `FSBL_OP_SGL_UNLOCK: sglEn = lockOk;
        default: sglEn = 1'b0;
      endcase
    end
  end

  // one-cycle requests to the non-volatile store and status logic
  always @(posedge clk_sys) begin
    if (srst) begin
      custLockProgram <= 1'b0;
      protSelProgram <= 1'b0;
      welClear <= 1'b0;
    end else begin
      custLockProgram <= custLockSet;
      protSelProgram <= protSelSet;
      welClear <= gangEn | sglEn;
    end
  end

  // ----------------------------------------------------------------
  // lock bits and protection answer
  // ----------------------------------------------------------------
  wire qryLockBit;
  // reset fills every lock from the scheme bit, so block mode powers up locked
  fsbl_lock_mem #(
    .N(`FSBL_NUM_LOCKS),
    .IW(`FSBL_IDX_W)
  ) u_locks (
    .clk_sys(clk_sys),
    .srst(srst),
    .initAll(nvProtSel),
    .write_enable_cmd(sglEn),
    .wrIdx(lockIdx(addr_q)),
    .wrVal(sglVal),
    .gangEn(gangEn),
    .gangVal(gangVal),
    .rdIdxA(lockIdx(addr_q)),
    .rdBitA(lockRdBit),
    .rdIdxB(lockIdx(qryAddr)),
    .rdBitB(qryLockBit)
  );

  // two cycles from query address to answer; the schemes never mix
  always @(posedge clk_sys) begin
    if (srst) begin
      qryProtected <= 1'b1;
      rangeBitsLocked <= 1'b0;
      blockSchemeActive <= `FSBL_RST_PROT_SEL;
    end else begin
      blockSchemeActive <= protSel_q;
      if (protSel_q)
        qryProtected <= wpLow | qryLockBit;
      else
        qryProtected <= rangeProtHit;
      rangeBitsLocked <= !protSel_q && statusWriteDisable && wpLow;
    end
  end

endmodule // fsbl_security_lock

// ===== sim/fsbl_host_model.sv
// Purpose: serial flash host that frames opcodes, addresses and reads in mode 0
// Assumes: 8 clk_sys per serial bit, which is the fastest rate the block accepts
// Notes: sclk rests low between frames; si is inverted once released
`timescale 1ns/1ps
module fsbl_host_model (
  input wire clk_sys,
  output reg csN,
  output reg sclk,
  output reg si,
  input wire soOut
);
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end
  task automatic hw(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // send nb bits of tx msb first, then clock in nr bytes; read bits are
  // sampled just before the next fall, well after the device moved them
  task automatic frame(input logic [31:0] tx, input int nb, input int nr,
                       output logic [7:0] rx);
    rx = 8'h00;
    csN <= 1'b0;
    hw(8);
    for (int i = 0; i < nb + 8 * nr; i++) begin
      si <= (i < nb) ? tx[31 - i] : ~si;
      hw(4);
      sclk <= 1'b1;
      hw(4);
      if (i >= nb)
        rx = {rx[6:0], soOut};
      sclk <= 1'b0;
    end
    hw(4);
    csN <= 1'b1;
    si <= ~si;
    hw(16);
  endtask
endmodule // fsbl_host_model

// ===== sim/fsbl_security_lock_assertions.sv
// Purpose: port assertions of the security and block lock logic
// Assumes: one clk_sys domain, srst synchronous active high
// Notes: windows allow for the pin synchronisers and the query pipe
`timescale 1ns/1ps
module fsbl_security_lock_chk (
  input wire clk_sys,
  input wire srst,
  input wire csN,
  input wire wpN,
  input wire soEnN,
  input wire opBusy,
  input wire statusWriteDisable,
  input wire rangeProtHit,
  input wire qryProtected,
  input wire rangeBitsLocked,
  input wire custLockProgram,
  input wire protSelProgram,
  input wire welClear,
  input wire blockSchemeActive
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // inputs held long enough to pass the synchronisers
  sequence sRangeSteady;
    (!blockSchemeActive && $stable(rangeProtHit))[*4];
  endsequence
  sequence sWpLowBlock;
    (blockSchemeActive && !wpN)[*8];
  endsequence
  sequence sRangeFrozen;
    (!blockSchemeActive && statusWriteDisable && !wpN)[*8];
  endsequence
  a_cs_high_quiet: assert property (csN[*8] |-> soEnN)
    else $error("so driven while deselected");
  a_range_follow: assert property (sRangeSteady |-> qryProtected == rangeProtHit)
    else $error("range mode query wrong");
  a_wp_all_prot: assert property (sWpLowBlock |-> qryProtected)
    else $error("wp low left a block open");
  a_range_freeze: assert property (sRangeFrozen |-> rangeBitsLocked)
    else $error("range bits not frozen");
  a_cust_pulse_ok: assert property (custLockProgram |-> !$past(opBusy) ##1 !custLockProgram)
    else $error("bad customer lock pulse");
  a_sel_once: assert property (protSelProgram |-> !$past(blockSchemeActive) ##[0:2] blockSchemeActive)
    else $error("bad scheme select");
  a_scheme_sticky: assert property (!$fell(blockSchemeActive))
    else $error("scheme bit returned to 0");
  a_wel_pulse: assert property (welClear |-> blockSchemeActive ##1 !welClear)
    else $error("bad write enable clear");
endmodule // fsbl_security_lock_chk
bind fsbl_security_lock fsbl_security_lock_chk chk (
  .clk_sys(clk_sys), .srst(srst), .csN(csN), .wpN(wpN), .soEnN(soEnN), .opBusy(opBusy),
  .statusWriteDisable(statusWriteDisable), .rangeProtHit(rangeProtHit),
  .qryProtected(qryProtected), .rangeBitsLocked(rangeBitsLocked),
  .custLockProgram(custLockProgram), .protSelProgram(protSelProgram),
  .welClear(welClear), .blockSchemeActive(blockSchemeActive)
);

// ===== sim/tb_top.sv
// Purpose: self-checking bench of the security and block lock logic
// Assumes: host model frames at 320 ns per serial bit
// Notes: expectations come from the bit map and opcodes only
`timescale 1ns/1ps
`include "fsbl_consts.vh"
module tb_top;
  reg clk_sys = 1'b0;
  reg srst = 1'b1;
  reg wpN = 1'b1;
  reg opBusy = 1'b0, contProgActive = 1'b0, progFailEvt = 1'b0, eraseFailEvt = 1'b0;
  reg otpModeActive = 1'b0, writeEnableLatch = 1'b0, statusWriteDisable = 1'b0;
  reg rangeProtHit = 1'b0, factoryOtpLock = 1'b0, nvCustLock = 1'b0, nvProtSel = 1'b0;
  reg [23:0] qryAddr = 24'h000000;
  wire csN, sclk, si, soOut, soEnN, qryProtected, rangeBitsLocked;
  wire custLockProgram, protSelProgram, welClear, blockSchemeActive;
  int numErrors = 0;
  int totalChecks = 0;
  int nCust = 0;
  int nSel = 0;
  int nWel = 0;
  logic [7:0] rx;
  // edge sectors of the bottom and top blocks and a plain block
  logic [23:0] adr [5] = '{24'h000000, 24'h00f000, 24'h7ff000, 24'h7f0000, 24'h123456};
  always #20 clk_sys = ~clk_sys;
  // count request pulses towards the stores outside the block
  always @(posedge clk_sys) begin
    nCust <= nCust + custLockProgram;
    nSel <= nSel + protSelProgram;
    nWel <= nWel + welClear;
  end
  fsbl_host_model host (.clk_sys(clk_sys), .csN(csN), .sclk(sclk), .si(si), .soOut(soOut));
  fsbl_security_lock uut (
    .clk_sys(clk_sys), .srst(srst), .csN(csN), .sclk(sclk), .si(si), .wpN(wpN),
    .soOut(soOut), .soEnN(soEnN), .opBusy(opBusy), .contProgActive(contProgActive),
    .progFailEvt(progFailEvt), .eraseFailEvt(eraseFailEvt), .otpModeActive(otpModeActive),
    .writeEnableLatch(writeEnableLatch), .statusWriteDisable(statusWriteDisable),
    .rangeProtHit(rangeProtHit), .factoryOtpLock(factoryOtpLock), .nvCustLock(nvCustLock),
    .nvProtSel(nvProtSel), .qryAddr(qryAddr), .qryProtected(qryProtected),
    .rangeBitsLocked(rangeBitsLocked), .custLockProgram(custLockProgram),
    .protSelProgram(protSelProgram), .welClear(welClear),
    .blockSchemeActive(blockSchemeActive));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic hw(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int nb);
    host.frame({op, a}, nb, 0, rx);
  endtask
  // two bytes in one frame, so the second proves the repeat
  task automatic rdsec(input logic [7:0] e, input string what);
    host.frame({`FSBL_OP_RD_SEC, 24'h0}, 8, 2, rx);
    check(what, rx & 8'hf3, e);
  endtask
  // wait covers pin synchronisers as well as the query pipe
  task automatic qry(input logic [23:0] a, input logic e);
    qryAddr <= a;
    hw(8);
    check("qryProtected", {7'h0, qryProtected}, {7'h0, e});
  endtask
  task automatic lockrd(input logic [23:0] a, input logic [7:0] e);
    host.frame({`FSBL_OP_LOCK_RD, a}, 32, 1, rx);
    check("lock read", rx, e);
  endtask
  task automatic rst(input logic sel);
    srst <= 1'b1;
    nvProtSel <= sel;
    hw(8);
    srst <= 1'b0;
    hw(6);
  endtask
  task automatic t_read;
    factoryOtpLock <= 1'b1;
    contProgActive <= 1'b1;
    opBusy <= 1'b1;
    rdsec(8'h11, "sec busy");
    check("soEnN", {7'h0, soEnN}, 8'h01);
    factoryOtpLock <= 1'b0;
    contProgActive <= 1'b0;
    opBusy <= 1'b0;
    rdsec(8'h00, "sec idle");
  endtask
  task automatic t_fail;
    progFailEvt <= 1'b1;
    hw(1);
    progFailEvt <= 1'b0;
    eraseFailEvt <= 1'b1;
    hw(2);
    eraseFailEvt <= 1'b0;
    rdsec(8'h60, "fail set");
    rdsec(8'h60, "fail sticky");
    // erase event held across the clear: the set must win
    fork
      cmd(`FSBL_OP_FAIL_CLR, 24'h0, 8);
      begin
        hw(70);
        eraseFailEvt <= 1'b1;
        hw(30);
        eraseFailEvt <= 1'b0;
      end
    join
    rdsec(8'h40, "fail set wins");
    cmd(`FSBL_OP_FAIL_CLR, 24'h0, 8);
    rdsec(8'h00, "fail clear");
  endtask
  task automatic t_cust;
    cmd(`FSBL_OP_WR_SEC, 24'h0, 9);
    opBusy <= 1'b1;
    cmd(`FSBL_OP_WR_SEC, 24'h0, 8);
    opBusy <= 1'b0;
    otpModeActive <= 1'b1;
    cmd(`FSBL_OP_WR_SEC, 24'h0, 8);
    otpModeActive <= 1'b0;
    check("cust refused", nCust[7:0], 8'h00);
    cmd(`FSBL_OP_WR_SEC, 24'h0, 8);
    cmd(`FSBL_OP_WR_SEC, 24'h0, 8);
    check("cust pulses", nCust[7:0], 8'h01);
    rdsec(8'h02, "cust lock");
  endtask
  task automatic t_range;
    statusWriteDisable <= 1'b1;
    wpN <= 1'b0;
    rangeProtHit <= 1'b1;
    qry(24'h123456, 1'b1);
    check("range locked", {7'h0, rangeBitsLocked}, 8'h01);
    rangeProtHit <= 1'b0;
    writeEnableLatch <= 1'b1;
    cmd(`FSBL_OP_GANG_LOCK, 24'h0, 8);
    qry(24'h123456, 1'b0);
    wpN <= 1'b1;
    hw(8);
    check("range free", {7'h0, rangeBitsLocked}, 8'h00);
  endtask
  task automatic t_block;
    writeEnableLatch <= 1'b0;
    cmd(`FSBL_OP_PROT_SEL, 24'h0, 8);
    cmd(`FSBL_OP_PROT_SEL, 24'h0, 8);
    check("sel pulses", nSel[7:0], 8'h01);
    rdsec(8'h82, "sel bit");
    wpN <= 1'b0;
    qry(24'h123456, 1'b1);
    wpN <= 1'b1;
    rangeProtHit <= 1'b1;
    qry(24'h123456, 1'b0);
    rangeProtHit <= 1'b0;
    cmd(`FSBL_OP_GANG_LOCK, 24'h0, 8);
    qry(24'h123456, 1'b0);
    writeEnableLatch <= 1'b1;
    cmd(`FSBL_OP_GANG_LOCK, 24'h0, 8);
    foreach (adr[k]) begin
      qry(adr[k], 1'b1);
      cmd(`FSBL_OP_SGL_UNLOCK, adr[k], 32);
      qry(adr[k], 1'b0);
      qry(adr[k] ^ ((adr[k][22:16] == 7'h00 || adr[k][22:16] == 7'h7f) ?
          24'h001000 : 24'h010000), 1'b1);
      lockrd(adr[k], 8'h00);
      cmd(`FSBL_OP_SGL_LOCK, adr[k], 32);
      lockrd(adr[k], 8'h01);
    end
    cmd(`FSBL_OP_GANG_UNLOCK, 24'h0, 8);
    foreach (adr[k]) qry(adr[k], 1'b0);
    check("wel clears", nWel[7:0], 8'h0c);
  endtask
  task automatic t_power;
    nvCustLock <= 1'b1;
    rst(1'b1);
    check("scheme", {7'h0, blockSchemeActive}, 8'h01);
    rdsec(8'h82, "power on");
    foreach (adr[k]) qry(adr[k], 1'b1);
    cmd(`FSBL_OP_GANG_UNLOCK, 24'h0, 8);
    qry(24'h400000, 1'b0);
  endtask
  task automatic completeRun;
    if (numErrors == 0 && totalChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    rst(1'b0);
    t_read;
    t_fail;
    t_cust;
    t_range;
    t_block;
    t_power;
    completeRun;
  end
  // tests need about 10000 clocks; four times that means a hang
  initial begin
    hw(40000);
    numErrors++;
    completeRun;
  end
endmodule // tb_top
